//--- mrs_pkg.sv
// package: constants and types for the mii receive status and strap block
package mrs_pkg;
    // interface modes selected by straps
    typedef enum logic [1:0] {
        MRS_MODE_MII,
        MRS_MODE_RMII,
        MRS_MODE_SERIAL
    } mrs_mode_type;

    // wishbone register byte addresses
    localparam logic [7:0] MRS_ADDR_CTRL = 8'h00;
    localparam logic [7:0] MRS_ADDR_STATUS = 8'h04;
    localparam logic [7:0] MRS_ADDR_ERRCNT = 8'h08;

    // control register bit positions
    localparam int MRS_CTRL_FULL_DUPLEX_BIT = 0;
    localparam int MRS_CTRL_ERR_ENABLE_BIT = 1;

    // reset values
    localparam logic [1:0] MRS_CTRL_RESET = 2'h2;
    localparam logic [15:0] MRS_ERRCNT_RESET = 16'h0000;

    // status register bit positions
    localparam int MRS_STAT_MODE_LSB = 0;
    localparam int MRS_STAT_REPEATER_BIT = 2;
    localparam int MRS_STAT_DETACH_BIT = 3;
    localparam int MRS_STAT_STRAPS_DONE_BIT = 4;
    localparam int MRS_STAT_CRS_BIT = 5;
    localparam int MRS_STAT_COL_BIT = 6;

    // recommended external reset hold time; only documented, not enforced
    localparam int MRS_RESET_HOLD_MS = 200;
    localparam int MRS_CLOCK_MHZ = 200;
    localparam longint MRS_RESET_HOLD_CYCLES =
        longint'(MRS_RESET_HOLD_MS) * 1000 * longint'(MRS_CLOCK_MHZ);
endpackage : mrs_pkg

//--- mrs_status.sv
// mrs_status: receive status outputs and power-on strap capture for a 10/100 phy
//
// Local design decisions: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
// Function
// - mii mode: error output rises on error, holds until data valid drops.
// - rmii mode: error output holds until combined carrier/valid drops.
// - serial mode: error output unused and kept low.
// - straps select mode: reduced high rmii, both low mii, serial high with reduced low serial.
// - repeater strap latched at reset, steers half duplex carrier sense.
// - repeater 0: carrier sense on receive and transmit in half duplex.
// - repeater 1: carrier sense only on receive in half duplex.
// - mii/serial: carrier sense on medium carrier; none in rmii.
// - carrier sense is asynchronous; mac synchronises it before use.
// - low reset input puts block into reset.
// - mii: data valid driven on rising receive clock edge.
// - rmii: combined carrier/valid asserted while medium not idle.
module mrs_status (
    input wire logic clock_i, // system clock, 200 mhz
    input wire logic reset_n_i, // asynchronous reset, active low
    input wire logic rx_clock_i, // link clock (rx clock or rmii reference)
    // strap pins, sampled at reset release
    input wire logic reduced_mii_strap_i, // reduced-mii strap pin
    input wire logic general_serial_mode_strap_i, // serial mode strap pin
    input wire logic repeater_strap_i, // repeater strap pin
    input wire logic port_detach_strap_i, // detach strap pin, stored only
    // receive side events from the phy core, rx clock domain
    input wire logic rx_active_i, // receive medium not idle
    input wire logic rx_valid_i, // receive nibble valid
    input wire logic rx_error_i, // error detected on current frame
    // medium state from the phy core, asynchronous
    input wire logic tx_active_i, // own transmission in progress
    input wire logic collision_i, // collision present on medium
    // wishbone classic slave
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write enable
    input wire logic [7:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte selects
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    output logic wb_err_o, // unmapped address
    // mac facing pins
    output logic rx_dv_o, // data valid (mii) or carrier/valid (rmii)
    output logic rx_er_o, // receive error
    output logic crs_o, // carrier sense, asynchronous to rx clock
    output logic col_o, // collision
    output logic pins_enable_o // strap-shared outputs driven
);
    import mrs_pkg::*;

    // ----------------------------------------------------------------
    // strap capture
    // ----------------------------------------------------------------
    // straps are taken on the third clock after reset release; async reset
    // loads only constants, so the pin levels are taken by a clocked process
    logic straps_done_reg;
    logic [1:0] strap_sync1_reg;
    logic [1:0] strap_sync2_reg;
    logic [1:0] strap_meta1_reg;
    logic [1:0] strap_meta2_reg;
    mrs_mode_type mode_reg;
    logic repeater_reg;
    logic detach_reg;

    function automatic mrs_mode_type mode_decode(input logic reduced, input logic serial);
        if (reduced) begin
            return MRS_MODE_RMII;
        end else if (serial) begin
            return MRS_MODE_SERIAL;
        end else begin
            return MRS_MODE_MII;
        end
    endfunction

    // straps are pins, so they pass two flip-flops before use
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            strap_meta1_reg <= 2'h0;
            strap_meta2_reg <= 2'h0;
            strap_sync1_reg <= 2'h0;
            strap_sync2_reg <= 2'h0;
        end else begin
            strap_meta1_reg <= {reduced_mii_strap_i, general_serial_mode_strap_i};
            strap_meta2_reg <= {repeater_strap_i, port_detach_strap_i};
            strap_sync1_reg <= strap_meta1_reg;
            strap_sync2_reg <= strap_meta2_reg;
        end
    end

    // count two edges so the synchronisers hold real pin levels first
    logic [1:0] settle_reg;
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            settle_reg <= 2'h0;
            straps_done_reg <= 1'b0;
            mode_reg <= MRS_MODE_MII;
            repeater_reg <= 1'b0;
            detach_reg <= 1'b0;
        end else if (!straps_done_reg) begin
            settle_reg <= settle_reg + 2'h1;
            if (settle_reg == 2'h2) begin
                straps_done_reg <= 1'b1;
                mode_reg <= mode_decode(strap_sync1_reg[1], strap_sync1_reg[0]);
                repeater_reg <= strap_sync2_reg[1];
                detach_reg <= strap_sync2_reg[0];
            end
        end
        // once done, values stay until the next reset
    end

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    logic [1:0] ctrl_reg;
    logic [15:0] errcnt_reg;
    logic ack_reg;
    logic err_reg;
    logic [31:0] rdata_reg;
    logic req;
    logic mapped;

    assign req = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
    assign mapped = (wb_adr_i == MRS_ADDR_CTRL) || (wb_adr_i == MRS_ADDR_STATUS)
        || (wb_adr_i == MRS_ADDR_ERRCNT);

    // carrier sense and collision are also reported in status
    logic crs_stat_meta_reg;
    logic crs_stat_reg;
    logic col_stat_meta_reg;
    logic col_stat_reg;

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= req && mapped;
            err_reg <= req && !mapped;
            if (req && !wb_we_i) begin
                case (wb_adr_i)
                    MRS_ADDR_CTRL: rdata_reg <= {30'h0, ctrl_reg};
                    MRS_ADDR_STATUS: begin
                        rdata_reg <= 32'h0;
                        rdata_reg[MRS_STAT_MODE_LSB +: 2] <= mode_reg;
                        rdata_reg[MRS_STAT_REPEATER_BIT] <= repeater_reg;
                        rdata_reg[MRS_STAT_DETACH_BIT] <= detach_reg;
                        rdata_reg[MRS_STAT_STRAPS_DONE_BIT] <= straps_done_reg;
                        rdata_reg[MRS_STAT_CRS_BIT] <= crs_stat_reg;
                        rdata_reg[MRS_STAT_COL_BIT] <= col_stat_reg;
                    end
                    MRS_ADDR_ERRCNT: rdata_reg <= {16'h0, errcnt_reg};
                    default: rdata_reg <= 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_reg <= MRS_CTRL_RESET;
        end else if (req && wb_we_i && wb_sel_i[0] && (wb_adr_i == MRS_ADDR_CTRL)) begin
            ctrl_reg <= wb_dat_i[1:0];
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_err_o = err_reg;
    assign wb_dat_o = rdata_reg;

    // ----------------------------------------------------------------
    // crossings into the link domain
    // ----------------------------------------------------------------
    // mode, strap-done and error enable are quasi-static levels: two flops each
    logic [3:0] cfg_meta_reg;
    logic [3:0] cfg_link_reg;
    always_ff @(posedge rx_clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cfg_meta_reg <= 4'h0;
            cfg_link_reg <= 4'h0;
        end else begin
            cfg_meta_reg <= {straps_done_reg, ctrl_reg[MRS_CTRL_ERR_ENABLE_BIT],
                mode_reg == MRS_MODE_RMII, mode_reg == MRS_MODE_SERIAL};
            cfg_link_reg <= cfg_meta_reg;
        end
    end

    logic link_ready;
    logic link_err_en;
    logic link_rmii;
    logic link_serial;
    assign link_ready = cfg_link_reg[3];
    assign link_err_en = cfg_link_reg[2];
    assign link_rmii = cfg_link_reg[1];
    assign link_serial = cfg_link_reg[0];

    // ----------------------------------------------------------------
    // link side: data valid and receive error
    // ----------------------------------------------------------------
    logic rx_dv_reg;
    logic rx_er_reg;
    logic err_toggle_reg;
    logic frame_valid;

    // rmii uses the medium-active flag, mii the nibble valid
    assign frame_valid = link_rmii ? rx_active_i : rx_valid_i;

    always_ff @(posedge rx_clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_dv_reg <= 1'b0;
        end else begin
            rx_dv_reg <= link_ready && !link_serial && frame_valid;
        end
    end

    // error latches and holds until the valid flag falls; a falling flag or disabled report wins
    always_ff @(posedge rx_clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_er_reg <= 1'b0;
            err_toggle_reg <= 1'b0;
        end else if (!link_ready || link_serial || !link_err_en) begin
            rx_er_reg <= 1'b0;
        end else if (rx_error_i && frame_valid) begin
            rx_er_reg <= 1'b1;
            if (!rx_er_reg) begin
                err_toggle_reg <= ~err_toggle_reg;
            end
        end else if (!frame_valid) begin
            rx_er_reg <= 1'b0;
        end
    end

    assign rx_dv_o = rx_dv_reg;
    assign rx_er_o = rx_er_reg;

    // error events counted in the system domain via toggle crossing
    logic [2:0] err_sync_reg;
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            err_sync_reg <= 3'h0;
            errcnt_reg <= MRS_ERRCNT_RESET;
        end else begin
            err_sync_reg <= {err_sync_reg[1:0], err_toggle_reg};
            if (err_sync_reg[2] != err_sync_reg[1]) begin
                errcnt_reg <= errcnt_reg + 16'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // carrier sense and collision
    // ----------------------------------------------------------------
    // medium inputs are asynchronous, synchronised before logic reads them
    logic [1:0] rxa_sync_reg;
    logic [1:0] txa_sync_reg;
    logic [1:0] col_sync_reg;
    logic crs_reg;
    logic col_reg;
    logic half_duplex;
    logic mii_like;

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rxa_sync_reg <= 2'h0;
            txa_sync_reg <= 2'h0;
            col_sync_reg <= 2'h0;
        end else begin
            rxa_sync_reg <= {rxa_sync_reg[0], rx_active_i};
            txa_sync_reg <= {txa_sync_reg[0], tx_active_i};
            col_sync_reg <= {col_sync_reg[0], collision_i};
        end
    end

    assign half_duplex = !ctrl_reg[MRS_CTRL_FULL_DUPLEX_BIT];
    assign mii_like = straps_done_reg && (mode_reg != MRS_MODE_RMII);

    // carrier sense runs on the system clock, unrelated to rx clock
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            crs_reg <= 1'b0;
        end else if (!mii_like) begin
            crs_reg <= 1'b0;
        end else if (half_duplex && !repeater_reg) begin
            crs_reg <= rxa_sync_reg[1] || txa_sync_reg[1];
        end else begin
            crs_reg <= rxa_sync_reg[1];
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            col_reg <= 1'b0;
        end else if (!mii_like || !half_duplex) begin
            col_reg <= 1'b0;
        end else begin
            col_reg <= col_sync_reg[1];
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            crs_stat_meta_reg <= 1'b0;
            crs_stat_reg <= 1'b0;
            col_stat_meta_reg <= 1'b0;
            col_stat_reg <= 1'b0;
        end else begin
            crs_stat_meta_reg <= crs_reg;
            crs_stat_reg <= crs_stat_meta_reg;
            col_stat_meta_reg <= col_reg;
            col_stat_reg <= col_stat_meta_reg;
        end
    end

    assign crs_o = crs_reg;
    assign col_o = col_reg;
    assign pins_enable_o = straps_done_reg;
endmodule // mrs_status

//--- mrs_status_props.sv
// checker: port-level properties of mrs_status
`timescale 1ns/10ps
module mrs_status_props (
    input wire logic clock_i, // system clock
    input wire logic reset_n_i, // reset, active low
    input wire logic rx_clock_i, // link clock
    input wire logic reduced_mii_strap_i, // reduced-mii strap
    input wire logic general_serial_mode_strap_i, // serial mode strap
    input wire logic repeater_strap_i, // repeater strap
    input wire logic rx_active_i, // medium not idle
    input wire logic rx_valid_i, // nibble valid
    input wire logic rx_error_i, // receive error
    input wire logic tx_active_i, // own transmission
    input wire logic collision_i, // medium collision
    input wire logic wb_we_i, // bus write enable
    input wire logic wb_ack_o, // bus acknowledge
    input wire logic pins_enable_o, // strap-shared outputs driven
    input wire logic [7:0] wb_adr_i, // address
    input wire logic [3:0] wb_sel_i, // selects
    input wire logic [31:0] wb_dat_i, // write data
    input wire logic rx_dv_o, // data valid pin
    input wire logic rx_er_o, // error pin
    input wire logic crs_o, // carrier sense pin
    input wire logic col_o // collision pin
);
    logic full_q;
    logic en_q;
    logic [1:0] en_s;
    wire logic serial = !reduced_mii_strap_i && general_serial_mode_strap_i;
    wire logic vf = reduced_mii_strap_i ? rx_active_i : rx_valid_i;
    wire logic dv_exp = vf && !serial;
    // both flops high: never ahead of the design's own crossing
    wire logic en_ok = (en_s == 2'h3);
    // -----------------------------
    // duplex mirror, ack edge lags the register by one, as does col_o
    // -----------------------------
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            full_q <= 1'b0;
            en_q <= 1'b1;
        end else if (wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0]) begin
            full_q <= wb_dat_i[0];
            en_q <= wb_dat_i[1];
        end
    end
    // -----------------------------
    // error report enable, carried into the link domain
    // -----------------------------
    always_ff @(posedge rx_clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            en_s <= 2'h0;
        end else begin
            en_s <= {en_s[0], en_q};
        end
    end
    sequence s_err;
        !serial && en_ok && vf && rx_error_i;
    endsequence
    property p_er_set;
        @(posedge rx_clock_i) disable iff (!reset_n_i) s_err |=> rx_er_o;
    endproperty
    a_er_set: assert property (p_er_set) else $error("rx error not raised");
    property p_er_hold;
        @(posedge rx_clock_i) disable iff (!reset_n_i) rx_er_o && vf && en_ok |=> rx_er_o;
    endproperty
    a_er_hold: assert property (p_er_hold) else $error("rx error dropped early");
    property p_er_clr;
        @(posedge rx_clock_i) disable iff (!reset_n_i) !vf |=> !rx_er_o;
    endproperty
    a_er_clr: assert property (p_er_clr) else $error("rx error kept too long");
    property p_er_off;
        @(posedge rx_clock_i) disable iff (!reset_n_i) serial |-> !rx_er_o;
    endproperty
    a_er_off: assert property (p_er_off) else $error("rx error in serial mode");
    property p_dv;
        @(posedge rx_clock_i) disable iff (!reset_n_i) 1'b1 |=> rx_dv_o == $past(dv_exp);
    endproperty
    a_dv: assert property (p_dv) else $error("data valid wrong");
    property p_crs;
        @(posedge clock_i) disable iff (!reset_n_i)
        pins_enable_o && $past(pins_enable_o, 3) && !reduced_mii_strap_i |-> crs_o ==
        ($past(rx_active_i, 3) || (!full_q && !repeater_strap_i && $past(tx_active_i, 3)));
    endproperty
    a_crs: assert property (p_crs) else $error("carrier sense wrong");
    property p_col;
        @(posedge clock_i) disable iff (!reset_n_i)
        pins_enable_o && $past(pins_enable_o, 3) && !reduced_mii_strap_i
        |-> col_o == (!full_q && $past(collision_i, 3));
    endproperty
    a_col: assert property (p_col) else $error("collision wrong");
    property p_rmii;
        @(posedge clock_i) disable iff (!reset_n_i)
        reduced_mii_strap_i && pins_enable_o |-> !crs_o && !col_o;
    endproperty
    a_rmii: assert property (p_rmii) else $error("carrier or collision in rmii");
    property p_pins;
        @(posedge clock_i) disable iff (!reset_n_i) pins_enable_o |=> pins_enable_o;
    endproperty
    a_pins: assert property (p_pins) else $error("pin enable dropped");
endmodule // mrs_status_props

//--- mrs_mac_model.sv
// mac side model: samples receive status, synchronises carrier sense
`timescale 1ns/10ps
module mrs_mac_model (
    input wire logic clock_i, // mac clock
    input wire logic rx_clock_i, // receive clock
    input wire logic rx_dv_i, // data valid pin
    input wire logic rx_er_i, // error pin
    input wire logic crs_i, // carrier sense pin
    output logic seen_dv_o, // sampled data valid
    output logic seen_er_o, // sampled error
    output logic crs_sync_o // synchronised carrier sense
);
    logic [1:0] crs_meta;
    // carrier sense has no clock relation, so two flops before use
    always_ff @(posedge clock_i) begin
        crs_meta <= {crs_meta[0], crs_i};
    end
    assign crs_sync_o = crs_meta[1];
    always_ff @(posedge rx_clock_i) begin
        seen_dv_o <= rx_dv_i;
        seen_er_o <= rx_er_i;
    end
endmodule // mrs_mac_model

//--- mrs_status_test.sv
// self-checking bench for mrs_status
`timescale 1ns/10ps
module mrs_status_test;
    import mrs_pkg::*;
    logic clock_i = 1'b0, rx_clock_i = 1'b0, reset_n_i = 1'b0;
    logic reduced_mii_strap_i = 1'b0, general_serial_mode_strap_i = 1'b0;
    logic repeater_strap_i = 1'b0, port_detach_strap_i = 1'b0;
    logic rx_active_i = 1'b0, rx_valid_i = 1'b0, rx_error_i = 1'b0;
    logic tx_active_i = 1'b0, collision_i = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic wb_ack_o, wb_err_o, rx_dv_o, rx_er_o, crs_o, col_o, pins_enable_o, bad;
    logic seen_dv, seen_er, crs_sync;
    int miscompares = 0, tests_run = 0, ser, md, errs, exp_dv, exp_er, en = 1;
    initial forever #2.5 clock_i = ~clock_i;
    // odd offset keeps link edges off the system clock grid
    initial begin
        #1.3;
        forever #32 rx_clock_i = ~rx_clock_i;
    end
    mrs_status i_dut (.clock_i, .reset_n_i, .rx_clock_i, .reduced_mii_strap_i,
        .general_serial_mode_strap_i, .repeater_strap_i, .port_detach_strap_i, .rx_active_i,
        .rx_valid_i, .rx_error_i, .tx_active_i, .collision_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .rx_dv_o, .rx_er_o,
        .crs_o, .col_o, .pins_enable_o);
    mrs_mac_model i_mac (.clock_i, .rx_clock_i, .rx_dv_i(rx_dv_o), .rx_er_i(rx_er_o),
        .crs_i(crs_o), .seen_dv_o(seen_dv), .seen_er_o(seen_er), .crs_sync_o(crs_sync));
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hf;
        wb_dat_i <= d;
        do begin
            @(posedge clock_i);
            n++;
        end while (!(wb_ack_o === 1'b1 || wb_err_o === 1'b1) && n < 20);
        rd = wb_dat_o;
        bad = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 20) begin
            miscompares++;
            give_verdict();
        end
    endtask
    task automatic do_reset(input logic [3:0] s);
        reset_n_i <= 1'b0;
        {reduced_mii_strap_i, general_serial_mode_strap_i} <= s[3:2];
        {repeater_strap_i, port_detach_strap_i} <= s[1:0];
        repeat (16) @(posedge clock_i); // hold scaled down for simulation
        chk("quiet in reset", 0, {crs_o, col_o, pins_enable_o, rx_er_o});
        reset_n_i <= 1'b1;
        errs = 0;
        repeat (40) @(posedge clock_i);
        chk("pins enable", 1, pins_enable_o);
    endtask
    task automatic rx_frame(input int n, input int p);
        logic vf;
        int nd, ne;
        for (int i = 0; i < n + 3; i++) begin
            @(posedge rx_clock_i);
            vf = reduced_mii_strap_i ? rx_active_i : rx_valid_i;
            nd = vf && !ser;
            ne = (ser || !en) ? 0 : (vf && rx_error_i) ? 1 : vf ? exp_er : 0;
            errs += (ne && !exp_er);
            rx_active_i <= i < n;
            rx_valid_i <= i < n - 1;
            rx_error_i <= i == p;
            #1;
            chk("rx valid", exp_dv, seen_dv);
            chk("rx error", exp_er, seen_er);
            exp_dv = nd;
            exp_er = ne;
        end
    endtask
    task automatic cc(input logic full);
        logic [2:0] r;
        logic exp_crs;
        logic exp_col;
        wb(1'b1, MRS_ADDR_CTRL, {30'h0, 1'b1, full});
        repeat (4) begin
            r = 3'($urandom);
            @(posedge clock_i);
            {rx_active_i, tx_active_i, collision_i} <= r;
            repeat (8) @(posedge clock_i);
            exp_crs = !reduced_mii_strap_i && (r[2] || (!full && !repeater_strap_i && r[1]));
            exp_col = !reduced_mii_strap_i && !full && r[0];
            chk("carrier", exp_crs, crs_sync);
            chk("collision", exp_col, col_o);
            wb(1'b0, MRS_ADDR_STATUS, 32'h0);
            chk("status carrier collision", {exp_crs, exp_col},
                {rd[MRS_STAT_CRS_BIT], rd[MRS_STAT_COL_BIT]});
        end
        {rx_active_i, tx_active_i, collision_i} <= 3'h0;
        wb(1'b0, MRS_ADDR_CTRL, 32'h0);
        chk("ctrl", {30'h0, 1'b1, full}, rd);
    endtask
    initial begin
        void'($urandom(32'h6fdde42d));
        for (int k = 0; k < 8; k++) begin
            do_reset({3'(k), 1'($urandom)});
            ser = !reduced_mii_strap_i && general_serial_mode_strap_i;
            md = reduced_mii_strap_i ? 1 : ser ? 2 : 0;
            exp_dv = 0;
            exp_er = 0;
            wb(1'b0, MRS_ADDR_STATUS, 32'h0);
            chk("status", {27'h0, 1'b1, port_detach_strap_i, repeater_strap_i,
                2'(md)}, rd);
            wb(1'b0, MRS_ADDR_CTRL, 32'h0);
            chk("ctrl reset", 32'h2, rd);
            wb(1'b0, 8'h0c, 32'h0);
            chk("unmapped", 1, bad);
            repeat (2) rx_frame(8, $urandom_range(8));
            // error report switched off: the pin must stay low, count must not move
            wb(1'b1, MRS_ADDR_CTRL, 32'h0);
            en = 0;
            repeat (3) @(posedge rx_clock_i);
            rx_frame(8, $urandom_range(7));
            en = 1;
            cc(1'b0);
            cc(1'b1);
            wb(1'b0, MRS_ADDR_ERRCNT, 32'h0);
            chk("error count", errs, rd);
            $display("strap set %0d done", k);
        end
        give_verdict();
    end
endmodule // mrs_status_test
bind mrs_status mrs_status_props i_props (.clock_i, .reset_n_i, .rx_clock_i,
    .reduced_mii_strap_i, .general_serial_mode_strap_i, .repeater_strap_i, .rx_active_i,
    .rx_valid_i, .rx_error_i, .tx_active_i, .collision_i, .wb_we_i, .wb_ack_o,
    .pins_enable_o, .wb_adr_i, .wb_sel_i, .wb_dat_i, .rx_dv_o, .rx_er_o, .crs_o, .col_o);
